// *** tx_clock_fail_detector.sv ***
// Purpose: Transmit clock failure detector with an APB register interface.
// Assumes: Single clock pclk at 100 MHz; master clock sampled through a synchroniser.
// Notes:   The count saturates at its maximum so the first window after a stopped master clock restarts fails any upper limit set below that maximum.
//
// Register access over APB and the placing of the registers were decided locally.
`default_nettype none

module tx_clock_fail_detector
	import tx_clock_fail_pkg::*;
(
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Observed master clock
	input  wire logic              tx_high_freq_master_clock,
	// Detector outputs
	output logic                   failure_autoswitch_enable,
	output logic                   tx_clock_fail_flag,
	output logic                   tx_interrupt
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		ctrl_s       ctrl;
		logic [7:0]  measured;
		logic [7:0]  count;
		logic [7:0]  pre;
		logic        fail;
		logic        fail_en;
		logic [31:0] rdata;
	} det_state_s;

	det_state_s st_r;
	det_state_s st_nxt;
	logic       window_done;
	logic       tick;
	logic       fail_event;
	logic       setup;
	logic       wr;
	logic       mapped;
	logic       ctrl_wr;
	logic       status_wr;
	logic       en_wr;

	tx_mclk_window tx_mclk_window_inst (
		.pclk                      (pclk),
		.presetn                   (presetn),
		.tx_high_freq_master_clock (tx_high_freq_master_clock),
		.window_done               (window_done)
	);

	// ************************************************************
	// Bus decode
	// ************************************************************
	assign setup     = psel & ~penable;
	assign wr        = psel & penable & pwrite;
	assign mapped    = (paddr == CTRL_OFFSET) | (paddr == STATUS_OFFSET) | (paddr == IRQ_EN_OFFSET);
	assign ctrl_wr   = wr & (paddr == CTRL_OFFSET);
	assign status_wr = wr & (paddr == STATUS_OFFSET);
	assign en_wr     = wr & (paddr == IRQ_EN_OFFSET);
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;

	// ************************************************************
	// Measurement
	// ************************************************************
	assign tick       = ((st_r.pre & prescale_mask(st_r.ctrl.ps)) == prescale_mask(st_r.ctrl.ps));
	assign fail_event = window_done &
	                    ((st_r.count > st_r.ctrl.upper) |
	                     (st_r.count < st_r.ctrl.lower));

	always_comb begin
		st_nxt     = st_r;
		st_nxt.pre = st_r.pre + COUNT_STEP;
		if (window_done) begin
			// Compare and capture use the synchronised window end only.
			st_nxt.measured = st_r.count;
			st_nxt.count    = tick ? COUNT_STEP : COUNT_RESET;
		end else if (tick && st_r.count != COUNT_MAX) begin
			st_nxt.count = st_r.count + COUNT_STEP;
		end
		if (ctrl_wr) begin
			st_nxt.ctrl.upper  = pwdata[UPPER_MSB:UPPER_LSB];
			st_nxt.ctrl.lower  = pwdata[LOWER_MSB:LOWER_LSB];
			st_nxt.ctrl.autosw = pwdata[AUTOSW_BIT];
			st_nxt.ctrl.ps     = pwdata[PS_MSB:PS_LSB];
		end
		if (en_wr) begin
			st_nxt.fail_en = pwdata[FAIL_BIT];
		end
		// A failure in the same cycle as a clear keeps the flag set.
		if (status_wr && pwdata[FAIL_BIT]) begin
			st_nxt.fail = 1'b0;
		end
		if (fail_event) begin
			st_nxt.fail = 1'b1;
		end
		// Read data is latched in the setup phase so prdata comes from a flop.
		if (setup) begin
			st_nxt.rdata = WORD_ZERO;
			if (paddr == CTRL_OFFSET) begin
				st_nxt.rdata[CNT_MSB:CNT_LSB]     = st_r.measured;
				st_nxt.rdata[UPPER_MSB:UPPER_LSB] = st_r.ctrl.upper;
				st_nxt.rdata[LOWER_MSB:LOWER_LSB] = st_r.ctrl.lower;
				st_nxt.rdata[AUTOSW_BIT]          = st_r.ctrl.autosw;
				st_nxt.rdata[PS_MSB:PS_LSB]       = st_r.ctrl.ps;
			end else if (paddr == STATUS_OFFSET) begin
				st_nxt.rdata[FAIL_BIT] = st_r.fail;
			end else if (paddr == IRQ_EN_OFFSET) begin
				st_nxt.rdata[FAIL_BIT] = st_r.fail_en;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{ctrl: CTRL_RESET, measured: COUNT_RESET, count: COUNT_RESET, pre: PRE_RESET,
			           fail: 1'b0, fail_en: 1'b0, rdata: WORD_ZERO};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata                    = st_r.rdata;
	assign failure_autoswitch_enable = st_r.ctrl.autosw;
	assign tx_clock_fail_flag        = st_r.fail;
	assign tx_interrupt              = st_r.fail & st_r.fail_en;

	// ************************************************************
	// Checks
	// ************************************************************
	property p_capture;
		@(posedge pclk) disable iff (!presetn)
		window_done |=> (st_r.measured == $past(st_r.count)) && (st_r.count <= COUNT_STEP);
	endproperty
	a_capture: assert property (p_capture) else $error("count not captured at window end");

	property p_upper;
		@(posedge pclk) disable iff (!presetn)
		(window_done && st_r.count > st_r.ctrl.upper) |=> tx_clock_fail_flag;
	endproperty
	a_upper: assert property (p_upper) else $error("upper limit breach not flagged");

	property p_lower;
		@(posedge pclk) disable iff (!presetn)
		(window_done && st_r.count < st_r.ctrl.lower) |=> tx_clock_fail_flag;
	endproperty
	a_lower: assert property (p_lower) else $error("lower limit breach not flagged");

	property p_autosw;
		@(posedge pclk) disable iff (!presetn)
		ctrl_wr |=> failure_autoswitch_enable == $past(pwdata[AUTOSW_BIT]);
	endproperty
	a_autosw: assert property (p_autosw) else $error("autoswitch enable not written");

	property p_prescale;
		@(posedge pclk) disable iff (!presetn)
		(tick && st_r.ctrl.ps == 4'h1 && !ctrl_wr) |=> !tick ##1 (tick || $past(ctrl_wr));
	endproperty
	a_prescale: assert property (p_prescale) else $error("divide by two spacing wrong");

	property p_reserved;
		@(posedge pclk) disable iff (!presetn)
		(setup && paddr == CTRL_OFFSET) |=> prdata[RSVD_MSB:RSVD_LSB] == 3'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved control bits not zero");

	property p_clear;
		@(posedge pclk) disable iff (!presetn)
		(status_wr && pwdata[FAIL_BIT] && !fail_event) |=> !tx_clock_fail_flag ##0 !tx_interrupt;
	endproperty
	a_clear: assert property (p_clear) else $error("write one did not clear fail flag");

	property p_set_wins;
		@(posedge pclk) disable iff (!presetn)
		(fail_event && status_wr) |=> tx_clock_fail_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("failure lost against a clear");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
		(!window_done && !(status_wr && pwdata[FAIL_BIT])) |=> tx_clock_fail_flag == $past(tx_clock_fail_flag);
	endproperty
	a_hold: assert property (p_hold) else $error("fail flag changed without cause");

	// A dead master clock must leave the count pinned at its maximum, never wrapped to a small value.
	property p_saturate;
		@(posedge pclk) disable iff (!presetn)
		(!window_done && st_r.count == COUNT_MAX) |=> st_r.count == COUNT_MAX;
	endproperty
	a_saturate: assert property (p_saturate) else $error("check count wrapped past its maximum");

	// Reserved prescale codes fall back to the largest divider, so ticks stay sparse.
	property p_reserved_code;
		@(posedge pclk) disable iff (!presetn)
		(tick && st_r.ctrl.ps > PS_MAX && !ctrl_wr) |=> !tick;
	endproperty
	a_reserved_code: assert property (p_reserved_code) else $error("reserved prescale code ticks too often");

	// Enabling the interrupt while the flag is already set must raise the request at once.
	property p_interrupt;
		@(posedge pclk) disable iff (!presetn)
		(en_wr && pwdata[FAIL_BIT] && tx_clock_fail_flag) |=> tx_interrupt;
	endproperty
	a_interrupt: assert property (p_interrupt) else $error("enabled fail flag gave no interrupt");

endmodule // tx_clock_fail_detector

`default_nettype wire

// *** tx_clock_fail_detector_tb_top.sv ***
// Purpose: Self-checking bench for the transmit clock failure detector.
// Assumes: Master clock period 40 ns, so one window is 128 system clocks.
// Notes:   Counts are checked with a small tolerance for synchroniser jitter.
`default_nettype none

module tx_clock_fail_detector_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import tx_clock_fail_pkg::*;

	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic              autosw, fail, irq, mclk, run;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [7:0]        half_ns;
	int                bad_count, n_tests;
	logic [3:0]        ps_tab [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
	logic [7:0]        lo_tab [6] = '{8'h7E, 8'h3E, 8'h1E, 8'h0E, 8'h00, 8'h00};
	logic [7:0]        hi_tab [6] = '{8'h82, 8'h42, 8'h22, 8'h12, 8'h01, 8'h01};

	tx_clock_fail_detector tx_clock_fail_detector_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_high_freq_master_clock(mclk), .failure_autoswitch_enable(autosw),
		.tx_clock_fail_flag(fail), .tx_interrupt(irq));
	tx_mclk_source tx_mclk_source_inst (.run(run), .half_ns(half_ns), .mclk(mclk));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			$display("[FAIL] %0t no pready", $time);
			bad_count++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic check_range(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		n_tests++;
		if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
			$display("[FAIL] %0t count %h outside %h..%h", $time, got, lo, hi);
			bad_count++;
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		{presetn, psel, penable, pwrite, run} = '0;
		paddr = '0;
		pwdata = '0;
		half_ns = 8'h14;
		bad_count = 0;
		n_tests = 0;
		idle(20);
		presetn <= 1'b1;
		xfer(CTRL_OFFSET, 1'b0, '0);
		check_word(rd, 32'h0000_0000);
		xfer(CTRL_OFFSET, 1'b1, 32'hFFFF_FFFF);
		xfer(CTRL_OFFSET, 1'b0, '0);
		check_word(rd, 32'h00FF_FF8F);
		check_word({31'h0, autosw}, 32'h1);
		xfer(CTRL_OFFSET, 1'b1, 32'h0000_0070);
		xfer(CTRL_OFFSET, 1'b0, '0);
		check_word({rd[31:1], autosw}, 32'h0);
		xfer(12'hFFC, 1'b0, '0);
		check_word({rd[30:0], err}, 32'h1);
		xfer(CTRL_OFFSET, 1'b1, 32'h00FF_0000);
		// The count saturates while the master clock is still stopped; the first window captures that.
		idle(300);
		run <= 1'b1;
		idle(140);
		xfer(CTRL_OFFSET, 1'b0, '0);
		check_word(rd, 32'hFFFF_0000);
		// Prescaler codes 0 to 3 and 8, and reserved code 9, each over full windows.
		for (int i = 0; i < 6; i++) begin
			xfer(CTRL_OFFSET, 1'b1, {8'h00, 8'hFF, 8'h00, 4'h0, ps_tab[i]});
			idle(450);
			xfer(CTRL_OFFSET, 1'b0, '0);
			check_range(rd[31:24], lo_tab[i], hi_tab[i]);
		end
		// The window that straddles a limit change is partial and may fail, so clear it first.
		xfer(CTRL_OFFSET, 1'b1, 32'h0084_7C00);
		idle(450);
		xfer(STATUS_OFFSET, 1'b1, 32'h0000_0004);
		idle(300);
		xfer(STATUS_OFFSET, 1'b0, '0);
		check_word(rd, 32'h0);
		xfer(CTRL_OFFSET, 1'b1, 32'h0070_0000);
		idle(450);
		xfer(STATUS_OFFSET, 1'b0, '0);
		check_word({rd[31:1], irq}, 32'h4);
		xfer(IRQ_EN_OFFSET, 1'b1, 32'hFFFF_FFFF);
		xfer(IRQ_EN_OFFSET, 1'b0, '0);
		check_word({rd[31:1], irq}, 32'h5);
		xfer(CTRL_OFFSET, 1'b1, 32'h00FF_0000);
		idle(450);
		xfer(STATUS_OFFSET, 1'b1, 32'hFFFF_FFFB);
		check_word({30'h0, fail, irq}, 32'h3);
		xfer(STATUS_OFFSET, 1'b1, 32'h0000_0004);
		idle(2);
		check_word({30'h0, fail, irq}, 32'h0);
		xfer(CTRL_OFFSET, 1'b1, 32'h00FF_9000);
		idle(450);
		check_word({30'h0, fail, irq}, 32'h3);
		test_done();
	end
endmodule // tx_clock_fail_detector_tb_top

`default_nettype wire

// *** tx_clock_fail_pkg.sv ***
// Purpose: Shared constants and types for the transmit clock failure detector.
// Assumes: APB slave with 32-bit data and a 12-bit byte address.
// Notes:   Offsets, field positions and multi-bit reset values are defined only here; single-bit flops reset to literal zeros.
`default_nettype none

package tx_clock_fail_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int         ADDR_W        = 12;
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] IRQ_EN_OFFSET = 12'h008;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int CNT_MSB    = 31;
	localparam int CNT_LSB    = 24;
	localparam int UPPER_MSB  = 23;
	localparam int UPPER_LSB  = 16;
	localparam int LOWER_MSB  = 15;
	localparam int LOWER_LSB  = 8;
	localparam int AUTOSW_BIT = 7;
	localparam int RSVD_MSB   = 6;
	localparam int RSVD_LSB   = 4;
	localparam int PS_MSB     = 3;
	localparam int PS_LSB     = 0;
	localparam int FAIL_BIT   = 2;

	// ************************************************************
	// Values
	// ************************************************************
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
	localparam logic [7:0]  COUNT_RESET  = 8'h00;
	localparam logic [7:0]  COUNT_MAX    = 8'hFF;
	localparam logic [7:0]  COUNT_STEP   = 8'h01;
	localparam logic [7:0]  PRE_RESET    = 8'h00;
	localparam logic [3:0]  PS_MAX       = 4'h8;
	localparam logic [4:0]  EDGE_RESET   = 5'h00;
	localparam logic [4:0]  EDGE_LAST    = 5'h1F;
	localparam logic [4:0]  EDGE_STEP    = 5'h01;

	typedef struct packed {
		logic [7:0] upper;
		logic [7:0] lower;
		logic       autosw;
		logic [3:0] ps;
	} ctrl_s;

	localparam ctrl_s CTRL_RESET = '{upper: 8'h00, lower: 8'h00, autosw: 1'b0, ps: 4'h0};

	// Divide by two to the code; reserved codes behave as the largest divider.
	function automatic logic [7:0] prescale_mask(input logic [3:0] ps);
		logic [3:0] eff;
		eff = (ps > PS_MAX) ? PS_MAX : ps;
		prescale_mask = 8'((9'h001 << eff) - 9'h001);
	endfunction

endpackage

`default_nettype wire

// *** tx_mclk_source.sv ***
// Purpose: Behavioural source of the transmit high-frequency master clock.
// Assumes: Half period given in ns; the clock is held low while stopped.
// Notes:   A small start offset keeps its edges away from the system clock edges.
`default_nettype none

module tx_mclk_source (
	// Control
	input  wire logic       run,
	input  wire logic [7:0] half_ns,
	// Clock out
	output var logic        mclk
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		mclk = 1'b0;
		#3;
		forever begin
			if (run === 1'b1) begin
				#(half_ns) mclk = ~mclk;
			end else begin
				mclk = 1'b0;
				@(posedge run);
				#3;
			end
		end
	end
endmodule // tx_mclk_source

`default_nettype wire

// *** tx_mclk_window.sv ***
// Purpose: Marks the end of every window of 32 master clock rising edges.
// Assumes: The master clock runs below half the system clock rate.
// Notes:   window_done is a one-cycle pulse in the system clock domain.
`default_nettype none

module tx_mclk_window
	import tx_clock_fail_pkg::*;
(
	// System clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Observed master clock
	input  wire logic tx_high_freq_master_clock,
	// Window end
	output logic      window_done
);

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [4:0] edges;
		logic       done;
	} win_state_s;

	win_state_s st_r;
	win_state_s st_nxt;
	logic       rise;

	assign rise = st_r.sync2 & ~st_r.prev;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.sync1 = tx_high_freq_master_clock;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev  = st_r.sync2;
		st_nxt.done  = 1'b0;
		if (rise) begin
			st_nxt.edges = st_r.edges + EDGE_STEP;
			st_nxt.done  = (st_r.edges == EDGE_LAST);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{sync1: 1'b0, sync2: 1'b0, prev: 1'b0, edges: EDGE_RESET, done: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign window_done = st_r.done;

	property p_window_end;
		@(posedge pclk) disable iff (!presetn)
		(rise && st_r.edges == EDGE_LAST) |=> window_done;
	endproperty
	a_window_end: assert property (p_window_end) else $error("window end not marked after 32 edges");

	property p_window_sync;
		@(posedge pclk) disable iff (!presetn)
		window_done |-> ($past(st_r.sync2) && !$past(st_r.prev)) ##1 !window_done;
	endproperty
	a_window_sync: assert property (p_window_sync) else $error("window end not from synchronised edge");

endmodule // tx_mclk_window

`default_nettype wire
